// *** core/ext_bus_pkg.sv ***
package ext_bus_pkg;
  // Machine cycle is twelve oscillator periods, two latch slots
  localparam int unsigned CYCLE_LEN       = 12;
  localparam logic [3:0]  PH_LAST         = 4'hb;
  // Strobe positions inside one machine cycle
  localparam logic [3:0]  PH_LATCH_A      = 4'h0;
  localparam logic [3:0]  PH_FETCH_A      = 4'h1;
  localparam logic [3:0]  PH_LATCH_B      = 4'h6;
  localparam logic [3:0]  PH_FETCH_B      = 4'h7;
  // Data strobe phases within the access cycle
  localparam logic [3:0]  PH_DATA_START   = 4'h6;
  localparam logic [3:0]  PH_DATA_END     = 4'h8;
  // Internal code boundary and reset vector
  localparam logic [15:0] INT_CODE_TOP    = 16'h3fff;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [7:0]  PORT_IDLE       = 8'hff;
  // Bit of the auxiliary register that suppresses latch pulses
  localparam int unsigned LATCH_OFF_BIT   = 0;
endpackage

// *** core/machine_phase.sv ***
`timescale 1ns/1ns
module machine_phase
  import ext_bus_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  output logic [3:0]      o_phase,
  output logic            o_cycle_end
);

  logic [3:0] phase_q;
  logic [3:0] phase_d;

  // Wraps after the last oscillator period of a machine cycle
  assign o_cycle_end = (phase_q == PH_LAST);
  assign phase_d     = o_cycle_end ? 4'h0 : phase_q + 4'h1;
  assign o_phase     = phase_q;

  // Phase counter
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      phase_q <= 4'h0;
    else
      phase_q <= phase_d;
  end

endmodule

// *** core/external_memory_bus_control.sv ***
// Functional notes
// - Two program strobes per external fetch cycle
// - Data access skips two program strobes
// - No program strobe on internal fetch
// - Latch pulse marks low address start
// - Latch pulses every six oscillator periods
// - Data access drops one latch pulse
// - Suppress bit blocks latch outside data moves
// - Suppressed latch only during data moves
// - Select low: all code external from zero
// - Write strobe per written data byte
// - Read strobe per read byte, memory drives
// - High address byte on second port
// - Low address and data on first port
// - Select high: external above internal boundary
// - Secured part latches select once after reset release
`timescale 1ns/1ns
module external_memory_bus_control
  import ext_bus_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_external_access_select,
  input  wire logic        i_secure_bit1,
  input  wire logic        i_latch_suppress,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_fetch,
  input  wire logic        i_data_req,
  input  wire logic        i_data_write,
  input  wire logic [15:0] i_data_addr,
  input  wire logic [7:0]  i_data_wdata,
  input  wire logic [7:0]  i_low_address_data_pins_in,
  output logic             o_program_store_strobe_n,
  output logic             o_addr_latch,
  output logic             o_data_read_n,
  output logic             o_data_write_n,
  output logic [7:0]       o_high_address_byte_pins,
  output logic [7:0]       o_low_address_data_pins_out,
  output logic             o_low_address_data_pins_oe,
  output logic [7:0]       o_code_byte,
  output logic             o_code_valid,
  output logic [7:0]       o_data_rbyte,
  output logic             o_data_rvalid,
  output logic             o_data_busy,
  output logic             o_fetch_external
);

  logic [3:0]  phase;
  logic        cycle_end;
  logic        sel_meta_q;
  logic        sel_sync_q;
  logic        sel_held_q;
  logic        sel_caught_q;
  logic        data_cyc_q;
  logic        data_cyc_d;
  logic        data_wr_q;
  logic [15:0] data_addr_q;
  logic [7:0]  data_wdata_q;
  logic [7:0]  din_meta_q;
  logic [7:0]  din_sync_q;
  logic        pstrobe_q;
  logic        latch_q;
  logic        rd_q;
  logic        wr_q;
  logic [7:0]  high_q;
  logic [7:0]  low_q;
  logic        low_oe_q;
  logic [7:0]  code_q;
  logic        code_v_q;
  logic [7:0]  rbyte_q;
  logic        rvalid_q;
  logic [1:0]  code_take_q;
  logic        rd_take_q;

  machine_phase u_phase (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .o_phase     (phase),
    .o_cycle_end (cycle_end)
  );

  // Pin input synchronisers
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      din_meta_q <= PORT_IDLE;
      din_sync_q <= PORT_IDLE;
    end
    else
    begin
      sel_meta_q <= i_external_access_select;
      sel_sync_q <= sel_meta_q;
      din_meta_q <= i_low_address_data_pins_in;
      din_sync_q <= din_meta_q;
    end
  end

  // Select level caught once after reset release
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_held_q   <= 1'b1;
      sel_caught_q <= 1'b0;
    end
    else if (!sel_caught_q && cycle_end)
    begin
      sel_held_q   <= sel_sync_q;
      sel_caught_q <= 1'b1;
    end
  end

  // Fetch source decision
  wire sel_level   = i_secure_bit1 ? sel_held_q : sel_sync_q;
  wire above_top   = (i_pc > INT_CODE_TOP);
  wire fetch_ext   = !sel_level || above_top;
  wire ext_fetch   = i_fetch && fetch_ext && !data_cyc_q;
  wire data_start  = cycle_end && i_data_req && !data_cyc_q;

  // Data access occupies one whole machine cycle
  assign data_cyc_d = data_start ? 1'b1 : (cycle_end ? 1'b0 : data_cyc_q);

  // Strobe timing decode
  wire fetch_ph    = (phase == PH_FETCH_A) || (phase == PH_FETCH_B);
  wire latch_ph    = (phase == PH_LATCH_A) || (phase == PH_LATCH_B);
  wire data_ph     = (phase >= PH_DATA_START) && (phase < PH_DATA_END);
  wire addr_ph     = latch_ph && !(data_cyc_q && phase == PH_LATCH_B);
  wire latch_reg   = addr_ph;
  wire latch_mov   = data_cyc_q && (phase == PH_LATCH_A);
  wire latch_d     = i_latch_suppress ? latch_mov : latch_reg;
  wire pstrobe_d   = ext_fetch && fetch_ph;
  wire rd_d        = data_cyc_q && !data_wr_q && data_ph;
  wire wr_d        = data_cyc_q && data_wr_q && data_ph;
  wire [15:0] addr = data_cyc_q ? data_addr_q : (fetch_ext ? i_pc : RESET_VECTOR);
  wire low_drv     = (data_cyc_q && data_wr_q && data_ph) || addr_ph;
  wire code_fall   = pstrobe_q && !pstrobe_d;
  wire rd_fall     = rd_q && !rd_d;

  // Data access request capture
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      data_cyc_q   <= 1'b0;
      data_wr_q    <= 1'b0;
      data_addr_q  <= RESET_VECTOR;
      data_wdata_q <= 8'h00;
    end
    else
    begin
      data_cyc_q <= data_cyc_d;
      if (data_start)
      begin
        data_wr_q    <= i_data_write;
        data_addr_q  <= i_data_addr;
        data_wdata_q <= i_data_wdata;
      end
    end
  end

  // Registered strobes and port drive
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pstrobe_q <= 1'b0;
      latch_q   <= 1'b0;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      high_q    <= PORT_IDLE;
      low_q     <= PORT_IDLE;
      low_oe_q  <= 1'b0;
    end
    else
    begin
      pstrobe_q <= pstrobe_d;
      latch_q   <= latch_d;
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      high_q    <= addr[15:8];
      low_q     <= addr_ph ? addr[7:0] : data_wdata_q;
      low_oe_q  <= low_drv;
    end
  end

  // Capture of bytes from the multiplexed port
  // Pin sync lags two clocks; the code take is delayed two clocks to match, the read take one
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      code_take_q <= 2'h0;
      rd_take_q   <= 1'b0;
      code_q      <= 8'h00;
      code_v_q    <= 1'b0;
      rbyte_q     <= 8'h00;
      rvalid_q    <= 1'b0;
    end
    else
    begin
      code_take_q <= {code_take_q[0], code_fall};
      rd_take_q   <= rd_fall;
      code_v_q    <= code_take_q[1];
      rvalid_q    <= rd_take_q;
      if (code_take_q[1])
        code_q <= din_sync_q;
      if (rd_take_q)
        rbyte_q <= din_sync_q;
    end
  end

  // Strobes leave the pins active low, the address latch pulse active high
  assign o_program_store_strobe_n    = !pstrobe_q;
  assign o_data_read_n               = !rd_q;
  assign o_data_write_n              = !wr_q;
  assign o_addr_latch                = latch_q;
  assign o_high_address_byte_pins    = high_q;
  assign o_low_address_data_pins_out = low_q;
  assign o_low_address_data_pins_oe  = low_oe_q;
  assign o_code_byte                 = code_q;
  assign o_code_valid                = code_v_q;
  assign o_data_rbyte                = rbyte_q;
  assign o_data_rvalid               = rvalid_q;
  assign o_data_busy                 = data_cyc_q;
  assign o_fetch_external            = fetch_ext;

endmodule

// *** dv/ebc_assertions.sv ***
`timescale 1ns/1ns
module ebc_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_latch_suppress,
  input wire logic o_program_store_strobe_n,
  input wire logic o_addr_latch,
  input wire logic o_data_read_n,
  input wire logic o_data_write_n,
  input wire logic o_low_address_data_pins_oe,
  input wire logic o_data_rvalid,
  input wire logic o_data_busy,
  input wire logic o_fetch_external
);
  // One clock domain, async reset
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // Data strobe held two clocks
  sequence s_two_low(x);
    !x ##1 !x ##1 x;
  endsequence
  // Strobe shapes and causes
  property p_program_store_strobe_len;
    $fell(o_program_store_strobe_n) |=> o_program_store_strobe_n;
  endproperty
  property p_program_store_strobe_src;
    $fell(o_program_store_strobe_n) |-> $past(o_fetch_external);
  endproperty
  property p_program_store_strobe_data;
    !o_data_read_n || !o_data_write_n |-> o_program_store_strobe_n;
  endproperty
  property p_rd_len;
    $fell(o_data_read_n) |-> s_two_low(o_data_read_n);
  endproperty
  property p_wr_len;
    $fell(o_data_write_n) |-> s_two_low(o_data_write_n);
  endproperty
  property p_wr_oe;
    !o_data_write_n |-> o_low_address_data_pins_oe;
  endproperty
  property p_rvalid;
    $rose(o_data_read_n) |-> ##[0:1] o_data_rvalid;
  endproperty
  property p_latch_sup;
    o_addr_latch && $past(i_latch_suppress) |-> o_data_busy;
  endproperty
  a_program_store_strobe_len: assert property (p_program_store_strobe_len) else $error("prog strobe long");
  a_program_store_strobe_src: assert property (p_program_store_strobe_src) else $error("prog strobe internal");
  a_program_store_strobe_data: assert property (p_program_store_strobe_data) else $error("prog strobe in data");
  a_rd_len: assert property (p_rd_len) else $error("read strobe width");
  a_wr_len: assert property (p_wr_len) else $error("write strobe width");
  a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
  a_rvalid: assert property (p_rvalid) else $error("read byte missing");
  a_latch_sup: assert property (p_latch_sup) else $error("latch not suppressed");
endmodule

// *** dv/ext_mem_model.sv ***
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic       i_clk_sys,
  input wire logic       i_latch,
  input wire logic       i_program_store_strobe_n,
  input wire logic       i_rd_n,
  input wire logic       i_wr_n,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_lo,
  output logic     [7:0] o_lo
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_q;
  logic [7:0] last_q = 8'h00;
  // Capture low address, store written bytes
  always @(posedge i_clk_sys)
  begin
    if (i_latch) lo_q <= i_lo;
    if (!i_wr_n) mem[{i_hi, lo_q}] <= i_lo;
    if (!i_rd_n || !i_program_store_strobe_n) last_q <= o_lo;
  end
  // Drive only during read or program strobe, else a changed value
  assign o_lo = (!i_rd_n || !i_program_store_strobe_n) ? mem[{i_hi, lo_q}] : ~last_q;
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        i_clk_sys, i_rst_n, i_external_access_select, i_secure_bit1;
  logic        i_latch_suppress, i_fetch, i_data_req, i_data_write;
  logic [15:0] i_pc, i_data_addr;
  logic [7:0]  i_data_wdata, i_low_address_data_pins_in, mem_lo, nl, np, rb;
  logic        o_program_store_strobe_n, o_addr_latch, o_data_read_n, o_data_write_n;
  logic        o_low_address_data_pins_oe, o_code_valid, o_data_rvalid, o_data_busy;
  logic        o_fetch_external;
  logic [7:0]  o_high_address_byte_pins, o_low_address_data_pins_out, o_code_byte, o_data_rbyte;
  int          error_cnt, tests_run, cyc;
  // Shared data pins
  assign i_low_address_data_pins_in = o_low_address_data_pins_oe ?
                                      o_low_address_data_pins_out : mem_lo;
  ext_mem_model u_mem (
    .i_clk_sys(i_clk_sys),
    .i_latch  (o_addr_latch),
    .i_program_store_strobe_n (o_program_store_strobe_n),
    .i_rd_n   (o_data_read_n),
    .i_wr_n   (o_data_write_n),
    .i_hi     (o_high_address_byte_pins),
    .i_lo     (i_low_address_data_pins_in),
    .o_lo     (mem_lo)
  );
  external_memory_bus_control DUT (.*);
  // Clock and hang guard
  initial
  begin
    i_clk_sys = 0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    i_rst_n = 0;
    repeat (2) tick();
    i_rst_n = 1;
  endtask
  // Count latch and program strobe pulses, keep any read byte
  task automatic count(input int n);
    nl = 0;
    np = 0;
    repeat (n)
    begin
      tick();
      nl += o_addr_latch;
      np += !o_program_store_strobe_n;
      if (o_data_rvalid === 1'b1) rb = o_data_rbyte;
    end
  endtask
  // One data move, held until taken
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (o_data_busy === 1'b1 && k < 24)
    begin
      tick();
      k++;
    end
    i_data_req = 1;
    i_data_write = w;
    i_data_addr = a;
    i_data_wdata = d;
    rb = 8'h00;
    k = 0;
    while (o_data_busy !== 1'b1 && k < 24)
    begin
      tick();
      k++;
    end
    i_data_req = 0;
    count(11);
  endtask
  task automatic t_internal();
    count(36);
    chk(nl, 8'h06);
    chk(np, 8'h00);
    chk(o_fetch_external, 8'h00);
  endtask
  task automatic t_boundary();
    i_pc = 16'h4000;
    repeat (2) tick();
    chk(o_fetch_external, 8'h01);
    count(12);
    chk(np, 8'h02);
    i_pc = 16'h3fff;
    tick();
    chk(o_fetch_external, 8'h00);
  endtask
  task automatic t_external();
    i_external_access_select = 0;
    do_reset();
    repeat (12) tick();
    chk(o_fetch_external, 8'h01);
    count(12);
    chk(np, 8'h02);
  endtask
  task automatic t_data();
    int k;
    access(1, 16'h5a3c, 8'ha5);
    chk(nl, 8'h01);
    chk(np, 8'h00);
    access(1, 16'h6a3c, 8'h3c);
    access(0, 16'h5a3c, 8'h00);
    chk(rb, 8'ha5);
    i_pc = 16'h5a3c;
    repeat (24) tick();
    k = 0;
    while (o_code_valid !== 1'b1 && k < 12)
    begin
      tick();
      k++;
    end
    chk(o_code_valid, 8'h01);
    chk(o_code_byte, 8'ha5);
    i_pc = 16'h0000;
  endtask
  task automatic t_suppress();
    i_external_access_select = 1;
    i_latch_suppress = 1;
    count(36);
    chk(nl, 8'h00);
    access(0, 16'h6a3c, 8'h00);
    chk(nl, 8'h01);
    chk(rb, 8'h3c);
    i_latch_suppress = 0;
  endtask
  task automatic t_secure();
    i_secure_bit1 = 1;
    i_external_access_select = 0;
    do_reset();
    repeat (12) tick();
    i_external_access_select = 1;
    repeat (6) tick();
    chk(o_fetch_external, 8'h01);
  endtask
  // Main sequence
  initial
  begin
    i_rst_n = 0;
    i_external_access_select = 1;
    i_secure_bit1 = 0;
    i_latch_suppress = 0;
    i_fetch = 1;
    i_data_req = 0;
    i_data_write = 0;
    i_pc = 16'h0000;
    i_data_addr = 16'h0000;
    i_data_wdata = 8'h00;
    do_reset();
    t_internal();
    t_boundary();
    t_external();
    t_data();
    t_suppress();
    t_secure();
    wrap_up();
  end
endmodule
bind external_memory_bus_control ebc_assertions u_chk (.*);
